/* bench/strap_board.sv */
`timescale 1ns/10ps
// Board side of the shared pins: strap resistors plus whatever the device drives
module strap_board (
   input wire logic [9:0] STRAP_OUT,
   input wire logic [9:0] STRAP_OE,
   input wire logic [9:0] STRAP_LVL,
   output logic [9:0] PIN
);
   // Once the device turns a pin into an output, its drive beats the weak board resistor
   always_comb begin
      for (int b = 0; b < 10; b++) begin
         PIN[b] = STRAP_OE[b] ? STRAP_OUT[b] : STRAP_LVL[b];
      end
   end
endmodule : strap_board

/* bench/strap_option_latch_tb.sv */
`timescale 1ns/10ps
module strap_option_latch_tb;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic [9:0] PIN_FUNC = 10'h0;
   strap_pkg::strap_s lvl = strap_pkg::STRAP_RESET;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [9:0] pin, oe, sout;
   logic [4:0] sa;
   logic [2:0] im;
   logic rmii, s100, fd, an, iso, done;
   logic done_d = 1'b0;
   logic rd_ph = 1'b0;
   int mismatches = 0;
   int cmp_count = 0;
   logic [31:0] rd_q[$];
   logic [32:0] cap_q[$];

   always #2 CLK = ~CLK;

   strap_option_latch #(.SETTLE_CYCLES(4)) DUT (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .STRAP_IN(pin), .STRAP_OUT(sout),
      .STRAP_OE(oe), .PIN_FUNC(PIN_FUNC), .STATION_ADDR(sa), .IFACE_MODE(im), .RMII_SEL(rmii),
      .SPEED_100(s100), .FULL_DUPLEX(fd), .AUTONEG_EN(an), .ISOLATE(iso), .STRAP_DONE(done));

   strap_board BOARD (.STRAP_OUT(sout), .STRAP_OE(oe), .STRAP_LVL(lvl), .PIN(pin));

   task chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task cmp_bus(input logic [31:0] got, input logic [31:0] exp);
      chk({hresp, got}, {1'b0, exp}, "register read");
   endtask : cmp_bus

   task cmp_pin(input logic [32:0] got, input logic [32:0] exp);
      chk(got, exp, "pin side outputs");
   endtask : cmp_pin

   task close_out;
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   function automatic logic [31:0] ctrl_of(input strap_pkg::strap_s s);
      return {18'h0, s.speed, s.aneg, 1'b0, s.iso, 1'b0, ~s.duplex, 8'h0};
   endfunction : ctrl_of

   // Read data is sampled at the edge that closes the data phase
   always @(posedge CLK) begin
      if (rd_ph && hreadyout) cmp_bus(hrdata, rd_q.pop_front());
   end

   // Pins stay inputs through the window; the capture shows once the window closes
   always @(negedge CLK) begin
      done_d <= done;
      if (!done) cmp_pin({13'h0, oe, sout}, 33'h0);
      if (done && !done_d) cmp_pin({sa, im, rmii, s100, fd, an, iso, oe, sout}, cap_q.pop_front());
   end

   // Single AHB transfer: hold each phase until hready is seen high
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      do begin @(posedge CLK); n++; end while (hreadyout !== 1'b1 && n < 50);
      HTRANS <= 2'h0;
      HWDATA <= d;
      rd_ph <= !wr;
      do begin @(posedge CLK); n++; end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) mismatches++;
      rd_ph <= 1'b0;
   endtask : bus

   task rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   // Reset with the given strap levels, then read back every seeded register
   task boot(input strap_pkg::strap_s s, input logic [9:0] pf);
      int n;
      n = 0;
      lvl <= s;
      PIN_FUNC <= pf;
      RST_N <= 1'b0;
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      cap_q.push_back({strap_pkg::ADDR_HI, s.addr, s.iface, s.iface == strap_pkg::IFACE_RMII, s.speed, ~s.duplex,
         s.aneg, s.iso, 10'h3FF, pf});
      do begin @(posedge CLK); n++; end while (done !== 1'b1 && n < 40);
      if (done !== 1'b1) mismatches++;
      rd(strap_pkg::OFS_CTRL, ctrl_of(s));
      rd(strap_pkg::OFS_ADV, {23'h0, s.speed, s.speed, 2'h3, strap_pkg::ADV_SELECTOR});
      rd(strap_pkg::OFS_STRAP, {21'h0, 1'b1, s});
   endtask : boot

   initial begin
      strap_pkg::strap_s s;
      int r;
      r = $urandom(16789);
      @(posedge CLK);
      boot(strap_pkg::STRAP_RESET, 10'h2A5);
      $display("test defaults done");
      // Every interface code once, other straps random
      for (int i = 0; i < 8; i++) begin
         s = strap_pkg::strap_s'(10'($urandom));
         s.iface = i[2:0];
         boot(s, 10'($urandom));
         $display("test strap set %0d done", i);
      end
      // Pins now carry output traffic; captures must not follow them
      PIN_FUNC <= ~PIN_FUNC;
      repeat (10) @(posedge CLK);
      rd(strap_pkg::OFS_STRAP, {21'h0, 1'b1, s});
      bus(1'b1, strap_pkg::OFS_CTRL, 32'hFFFFFFFF);
      rd(strap_pkg::OFS_CTRL, 32'h00003500);
      bus(1'b1, strap_pkg::OFS_CTRL, 32'h0);
      rd(strap_pkg::OFS_CTRL, 32'h0);
      rd(8'h0C, 32'h0);
      $display("test overwrite done");
      close_out;
   end

   // Whole run is under two hundred cycles; this bound leaves wide margin
   initial begin
      #40000;
      mismatches++;
      close_out;
   end
endmodule : strap_option_latch_tb

/* rtl/strap_option_latch.sv */
`timescale 1ns/10ps
// Notes on behaviour
// (R01) Sample all straps during reset, hold them; code samples at window end, after reset release
// (R02) Strap pins input only in reset, else drive; code keeps them inputs until the window closes
// (R03) Three address straps give station address
// (R04) Unstrapped station address is 00001
// (R05) Address bits four and three always zero
// (R06) Interface code 001 means RMII, others reserved
// (R07) Isolate strap high enables isolate
// (R08) Isolate strap seeds control bit 10
// (R09) Speed strap high 100, low 10
// (R10) Speed strap seeds control bit 13
// (R11) Speed strap seeds advertised speed abilities
// (R12) Duplex strap high half, low full
// (R13) Duplex strap seeds control bit 8
// (R14) Autoneg strap high enables autoneg
// (R15) Autoneg enable lives in control bit 12
// (R16) Captures fixed until reset; software may overwrite
module strap_option_latch #(
   parameter int SETTLE_CYCLES = strap_pkg::SETTLE_CYCLES_DEF
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [9:0] STRAP_IN,
   output logic [9:0] STRAP_OUT,
   output logic [9:0] STRAP_OE,
   input wire logic [9:0] PIN_FUNC,
   output logic [4:0] STATION_ADDR,
   output logic [2:0] IFACE_MODE,
   output logic RMII_SEL,
   output logic SPEED_100,
   output logic FULL_DUPLEX,
   output logic AUTONEG_EN,
   output logic ISOLATE,
   output logic STRAP_DONE
);
   // Refused at elaboration: the 8-bit window counter and the synchroniser fill set the range
   if (SETTLE_CYCLES < strap_pkg::SETTLE_CYCLES_MIN || SETTLE_CYCLES > 255) begin : g_settle_bad
      $error("SETTLE_CYCLES out of range");
   end

   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

   strap_pkg::phase_e phase_reg;
   logic [7:0] settle_cnt_reg;
   logic [9:0] sync1_reg;
   logic [9:0] sync2_reg;
   logic [9:0] sync3_reg;
   logic [9:0] filt_reg;
   strap_pkg::strap_s capt_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] adv_reg;
   strap_pkg::ahb_req_s req_reg;
   logic [31:0] rdata_reg;
   logic running;
   logic wr_ctrl;
   logic wr_adv;

   assign running = phase_reg == strap_pkg::ST_RUN;

   // Three-stage pin synchroniser; stage one feeds only stage two
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_reg <= strap_pkg::STRAP_RESET;
         sync2_reg <= strap_pkg::STRAP_RESET;
         sync3_reg <= strap_pkg::STRAP_RESET;
      end else begin
         sync1_reg <= STRAP_IN;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // A pin level counts only once stages two and three agree
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         filt_reg <= strap_pkg::STRAP_RESET;
      end else begin
         for (int i = 0; i < strap_pkg::STRAP_W; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
               filt_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   // Strap window extends past reset release so the synchroniser fills
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         phase_reg <= strap_pkg::ST_SETTLE;
         settle_cnt_reg <= 8'h00;
      end else begin
         unique case (phase_reg)
            strap_pkg::ST_SETTLE: begin
               settle_cnt_reg <= settle_cnt_reg + 8'h01;
               if (settle_cnt_reg == SETTLE_LAST) begin
                  phase_reg <= strap_pkg::ST_LATCH;
               end
            end
            strap_pkg::ST_LATCH: phase_reg <= strap_pkg::ST_RUN;
            strap_pkg::ST_RUN: phase_reg <= strap_pkg::ST_RUN;
            default: phase_reg <= strap_pkg::ST_SETTLE;
         endcase
      end
   end

   // Capture once per reset, then frozen
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         capt_reg <= strap_pkg::STRAP_RESET; // [R04]
      end else if (phase_reg == strap_pkg::ST_LATCH) begin
         capt_reg <= filt_reg; // [R01] [R03] [R06] [R16]
      end
   end

   // Pins are inputs with pulls in the window, driven afterwards
   assign STRAP_OE = running ? 10'h3FF : 10'h000; // [R02]
   assign STRAP_OUT = running ? PIN_FUNC : 10'h000; // [R02]

   // Station address: high bits tied, low bits from straps
   assign STATION_ADDR = {strap_pkg::ADDR_HI, capt_reg.addr}; // [R03] [R05]
   assign IFACE_MODE = capt_reg.iface;
   assign RMII_SEL = capt_reg.iface == strap_pkg::IFACE_RMII; // [R06]
   assign STRAP_DONE = running;

   // Mode outputs follow the live control register
   assign SPEED_100 = ctrl_reg[strap_pkg::CTRL_SPEED];
   assign FULL_DUPLEX = ctrl_reg[strap_pkg::CTRL_DUP];
   assign AUTONEG_EN = ctrl_reg[strap_pkg::CTRL_ANEG]; // [R15]
   assign ISOLATE = ctrl_reg[strap_pkg::CTRL_ISO];

   // AHB address phase, taken whenever the bus is ready
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         req_reg <= '0;
      end else if (HREADY) begin
         req_reg.valid <= HSEL && HTRANS[1];
         req_reg.write <= HWRITE;
         req_reg.addr <= HADDR[7:0];
      end
   end

   // Writes before the window closes would be overwritten by the seed
   assign wr_ctrl = req_reg.valid && req_reg.write && running
                    && strap_pkg::reg_hit(req_reg.addr, strap_pkg::OFS_CTRL);
   assign wr_adv = req_reg.valid && req_reg.write && running
                   && strap_pkg::reg_hit(req_reg.addr, strap_pkg::OFS_ADV);

   // Control register seeded by straps; duplex strap high means half
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_reg <= 16'h0000;
      end else if (phase_reg == strap_pkg::ST_LATCH) begin
         ctrl_reg <= 16'h0000;
         ctrl_reg[strap_pkg::CTRL_ISO] <= filt_reg[3]; // [R07] [R08]
         ctrl_reg[strap_pkg::CTRL_SPEED] <= filt_reg[2]; // [R09] [R10]
         ctrl_reg[strap_pkg::CTRL_DUP] <= ~filt_reg[1]; // [R12] [R13]
         ctrl_reg[strap_pkg::CTRL_ANEG] <= filt_reg[0]; // [R14] [R15]
      end else if (wr_ctrl) begin
         ctrl_reg[strap_pkg::CTRL_ISO] <= HWDATA[strap_pkg::CTRL_ISO]; // [R16]
         ctrl_reg[strap_pkg::CTRL_SPEED] <= HWDATA[strap_pkg::CTRL_SPEED];
         ctrl_reg[strap_pkg::CTRL_DUP] <= HWDATA[strap_pkg::CTRL_DUP];
         ctrl_reg[strap_pkg::CTRL_ANEG] <= HWDATA[strap_pkg::CTRL_ANEG]; // [R15]
      end
   end

   // Advertisement: 100 abilities seeded only when the speed strap is high; software writes to bits 8:5 may change them
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         adv_reg <= {11'h000, strap_pkg::ADV_SELECTOR};
      end else if (phase_reg == strap_pkg::ST_LATCH) begin
         adv_reg <= {11'h000, strap_pkg::ADV_SELECTOR};
         adv_reg[strap_pkg::ADV_100FD] <= filt_reg[2]; // [R11]
         adv_reg[strap_pkg::ADV_100HD] <= filt_reg[2]; // [R11]
         adv_reg[strap_pkg::ADV_10FD] <= 1'h1;
         adv_reg[strap_pkg::ADV_10HD] <= 1'h1;
      end else if (wr_adv) begin
         adv_reg[8:5] <= HWDATA[8:5]; // [R16]
      end
   end

   // Read data registered in the address phase; unmapped reads zero
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_reg <= 32'h0000_0000;
      end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
         if (strap_pkg::reg_hit(HADDR[7:0], strap_pkg::OFS_CTRL)) begin
            rdata_reg <= {16'h0000, ctrl_reg};
         end else if (strap_pkg::reg_hit(HADDR[7:0], strap_pkg::OFS_ADV)) begin
            rdata_reg <= {16'h0000, adv_reg};
         end else if (strap_pkg::reg_hit(HADDR[7:0], strap_pkg::OFS_STRAP)) begin
            rdata_reg <= {21'h0, running, STATION_ADDR[2:0], capt_reg[6:0]};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Zero-wait slave, always OKAY
   assign HRDATA = rdata_reg;
   assign HREADYOUT = 1'h1;
   assign HRESP = 1'h0;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence latch_step;
      phase_reg == strap_pkg::ST_LATCH;
   endsequence

   sequence seeded_ctrl;
      ctrl_reg[strap_pkg::CTRL_ISO] == capt_reg.iso
      && ctrl_reg[strap_pkg::CTRL_SPEED] == capt_reg.speed
      && ctrl_reg[strap_pkg::CTRL_DUP] == !capt_reg.duplex
      && ctrl_reg[strap_pkg::CTRL_ANEG] == capt_reg.aneg;
   endsequence

   pins_float_a: assert property ( // [R02]
      !running |-> STRAP_OE == 10'h000)
      else $error("strap pin driven inside window");

   pins_drive_a: assert property ( // [R02]
      running |-> STRAP_OE == 10'h3FF && STRAP_OUT == PIN_FUNC)
      else $error("strap pin not driven after window");

   addr_high_a: assert property ( // [R05]
      STATION_ADDR[4:3] == 2'h0)
      else $error("station address high bits not zero");

   window_len_a: assert property ( // [R01]
      $rose(phase_reg == strap_pkg::ST_LATCH) |-> ##1 running
      ##1 running[*8])
      else $error("window did not close into run");

   ctrl_seed_a: assert property ( // [R08]
      latch_step ##1 1'b1 |-> seeded_ctrl)
      else $error("control bits not seeded from straps");

   capt_src_a: assert property ( // [R01]
      latch_step |=> capt_reg == $past(filt_reg))
      else $error("capture does not match sampled pins");

   capt_hold_a: assert property ( // [R16]
      running && $past(running) |-> $stable(capt_reg))
      else $error("captured straps changed after window");

   adv_speed_a: assert property ( // [R11]
      latch_step |=> adv_reg[strap_pkg::ADV_100FD] == capt_reg.speed
      && adv_reg[strap_pkg::ADV_100HD] == capt_reg.speed)
      else $error("advertised speed does not follow strap");

   rmii_code_a: assert property ( // [R06]
      RMII_SEL == (IFACE_MODE == 3'h1))
      else $error("interface mode decode wrong");

   aneg_out_a: assert property ( // [R15]
      ##1 AUTONEG_EN == ctrl_reg[strap_pkg::CTRL_ANEG])
      else $error("autoneg output not from control bit 12");

   out_quiet_a: assert property ( // [R02]
      !running |-> STRAP_OUT == 10'h000)
      else $error("strap pin output value not quiet inside window");

   addr_seed_a: assert property ( // [R03]
      latch_step |=> {STATION_ADDR[2:0], 7'h00} == ($past(filt_reg) & 10'h380))
      else $error("station address not taken from address straps");

   iface_seed_a: assert property ( // [R06]
      latch_step |=> {3'h0, IFACE_MODE, 4'h0} == ($past(filt_reg) & 10'h070))
      else $error("interface code not taken from interface straps");

   adv_fixed_a: assert property ( // [R11]
      running |-> adv_reg[4:0] == strap_pkg::ADV_SELECTOR && adv_reg[15:9] == 7'h00)
      else $error("advertisement fixed fields disturbed");

   ctrl_spare_a: assert property ( // [R16]
      (ctrl_reg & 16'hCAFF) == 16'h0000)
      else $error("control register bit outside mode fields set");

   // Edges since reset release, saturating, so the window length is checked from outside the phase logic
   logic [8:0] since_rst_reg;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         since_rst_reg <= 9'h000;
      end else if (since_rst_reg != 9'h1FF) begin
         since_rst_reg <= since_rst_reg + 9'h001;
      end
   end

   done_time_a: assert property ( // [R01]
      $rose(STRAP_DONE) |-> since_rst_reg == 9'(SETTLE_CYCLES + 1))
      else $error("strap window closed at wrong cycle");
endmodule : strap_option_latch

/* rtl/strap_pkg.sv */
package strap_pkg;
   // Strap bundle, pin order follows the field order (MSB first)
   typedef struct packed {
      logic [2:0] addr;
      logic [2:0] iface;
      logic iso;
      logic speed;
      logic duplex;
      logic aneg;
   } strap_s;

   localparam int STRAP_W = 10;
   // Levels given by the internal pulls when nothing is strapped
   localparam logic [9:0] STRAP_RESET = {3'h1, 3'h0, 1'h0, 1'h1, 1'h1, 1'h1};
   localparam logic [1:0] ADDR_HI = 2'h0;
   localparam logic [2:0] IFACE_RMII = 3'h1;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADV = 8'h04;
   localparam logic [7:0] OFS_STRAP = 8'h08;

   // Basic control bits
   localparam int CTRL_SPEED = 13;
   localparam int CTRL_ANEG = 12;
   localparam int CTRL_ISO = 10;
   localparam int CTRL_DUP = 8;
   // Advertisement bits
   localparam int ADV_100FD = 8;
   localparam int ADV_100HD = 7;
   localparam int ADV_10FD = 6;
   localparam int ADV_10HD = 5;
   localparam logic [4:0] ADV_SELECTOR = 5'h01;

   localparam int SETTLE_CYCLES_DEF = 8;
   localparam int SETTLE_CYCLES_MIN = 4;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'h0,
      ST_LATCH = 2'h1,
      ST_RUN = 2'h3
   } phase_e;

   // Pending AHB data phase
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic valid;
   } ahb_req_s;

   // Register offset match on the low address byte
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : reg_hit
endpackage : strap_pkg
